/* core/dmc_pkg.sv */
// constants shared by the dma channel mode control block
package dmc_pkg;
    localparam int NUM_CH = 6;
    localparam int CH_IDX_W = 3;
    localparam int TRIG_SRC_N = 18;

    // register map, byte addresses on an 8-bit apb address
    localparam logic [7:0] MODE_BASE = 8'h00;
    localparam logic [7:0] CTRL_BASE = 8'h20;
    localparam logic [7:0] SIZE_BASE = 8'h40;
    localparam logic [7:0] ACTIVE_OFF = 8'h60;
    localparam logic [7:0] ISTAT_OFF = 8'h64;
    localparam logic [7:0] IMASK_OFF = 8'h68;
    localparam logic [2:0] REGION_MODE = 3'h0;
    localparam logic [2:0] REGION_CTRL = 3'h1;
    localparam logic [2:0] REGION_SIZE = 3'h2;

    // channel_mode_config fields
    localparam int MODE_CHAN_IRQ_ENABLE = 15;
    localparam int MODE_WORD_WIDTH_SELECT = 14;
    localparam int MODE_UNUSED_SYNC_SELECT = 13;
    localparam int MODE_UNUSED_SYNC_ENABLE = 12;
    localparam int MODE_CONTINUOUS = 11;
    localparam int MODE_AUTO_BURST_CHAINING = 10;
    localparam int MODE_CHAN_IRQ_TIMING = 9;
    localparam int MODE_TRIGGER_GATE_ENABLE = 8;
    localparam int MODE_OVERFLOW_IRQ_ENABLE = 7;
    localparam int MODE_SRC_MSB = 4;
    localparam int MODE_SRC_LSB = 0;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] MODE_WR_MASK = 16'hFF9F;

    // channel control word: write bits act once, read bits show state
    localparam int CTRL_RUN = 0;
    localparam int CTRL_HALT = 1;
    localparam int CTRL_FORCE = 3;
    localparam int CTRL_PEND_CLR = 4;
    localparam int CTRL_ERR_CLR = 7;
    localparam int CTRL_PEND_STS = 8;
    localparam int CTRL_RUN_STS = 13;
    localparam int CTRL_OVF_STS = 14;

    // size word: low byte burst words minus one, high byte bursts minus one
    localparam logic [15:0] SIZE_RESET = 16'h0000;
    localparam int ISTAT_OVF_LSB = 8;
    localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
    localparam logic [CH_IDX_W-1:0] NO_ACTIVE = 3'h0;
endpackage : dmc_pkg

/* core/dmc_channel.sv */
// one dma channel: trigger latch, burst and transfer sequencing
`timescale 1ns/1ps
`default_nettype none
module dmc_channel
    import dmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] mode,
    input wire logic [15:0] size_cfg,
    input wire logic periph_evt,
    input wire logic run_set,
    input wire logic halt_set,
    input wire logic force_set,
    input wire logic pend_clr,
    input wire logic err_clr,
    input wire logic grant,
    output logic want,
    output logic busy,
    output logic done,
    output logic move,
    output logic wide,
    output logic pend_sts,
    output logic run_sts,
    output logic ovf_sts,
    output logic chan_evt,
    output logic ovf_evt
);
    typedef enum logic [0:0] {CH_IDLE, CH_BURST} dmc_ch_state_type;

    dmc_ch_state_type state_ff;
    logic pend_ff;
    logic ovf_ff;
    logic run_ff;
    logic chain_ff;
    logic first_ff;
    logic [8:0] word_ff;
    logic [7:0] burst_ff;
    logic gate;
    logic accept;
    logic start;
    logic [8:0] step;
    logic last_burst;

    assign gate = mode[MODE_TRIGGER_GATE_ENABLE]; // RULE_12
    assign accept = gate & (periph_evt | force_set); // RULE_12 RULE_17
    assign want = run_ff & (pend_ff | chain_ff) & (state_ff == CH_IDLE);
    assign start = want & grant;
    // counts stay in 16-bit words; a wide move only consumes two of them
    assign step = mode[MODE_WORD_WIDTH_SELECT] ? 9'h002 : 9'h001; // RULE_04
    assign busy = (state_ff == CH_BURST);
    assign done = busy & (word_ff <= step);
    assign last_burst = (burst_ff == 8'h00);
    assign move = busy;
    assign wide = mode[MODE_WORD_WIDTH_SELECT]; // RULE_03
    assign pend_sts = pend_ff;
    assign run_sts = run_ff;
    assign ovf_sts = ovf_ff;
    // sync select and sync enable bits are stored but steer nothing
    assign ovf_evt = gate & periph_evt & pend_ff; // RULE_14
    assign chan_evt = (start & first_ff & ~mode[MODE_CHAN_IRQ_TIMING])
        | (done & last_burst & mode[MODE_CHAN_IRQ_TIMING]); // RULE_11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
        end else if (accept) begin
            pend_ff <= 1'b1; // RULE_15
        end else if ((start & ~chain_ff) | pend_clr) begin
            pend_ff <= 1'b0; // RULE_15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_ff <= 1'b0;
        end else if (ovf_evt) begin
            ovf_ff <= 1'b1; // RULE_14
        end else if (err_clr) begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
        end else if (run_set) begin
            run_ff <= 1'b1;
        end else if (halt_set) begin
            run_ff <= 1'b0;
        end else if (done & last_burst & ~mode[MODE_CONTINUOUS]) begin
            run_ff <= 1'b0; // RULE_08
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= CH_IDLE;
            word_ff <= 9'h000;
            burst_ff <= 8'h00;
            chain_ff <= 1'b0;
            first_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                CH_IDLE: begin
                    if (run_set) begin
                        burst_ff <= size_cfg[15:8];
                        first_ff <= 1'b1;
                        chain_ff <= 1'b0;
                    end else if (start) begin
                        word_ff <= {1'b0, size_cfg[7:0]} + 9'h001;
                        first_ff <= 1'b0;
                        state_ff <= CH_BURST;
                    end
                end
                CH_BURST: begin
                    if (done) begin
                        state_ff <= CH_IDLE;
                        if (last_burst) begin
                            // reload and wait for a fresh trigger
                            burst_ff <= size_cfg[15:8]; // RULE_07
                            first_ff <= 1'b1; // RULE_07
                            chain_ff <= 1'b0; // RULE_07
                        end else begin
                            burst_ff <= burst_ff - 8'h01;
                            chain_ff <= mode[MODE_AUTO_BURST_CHAINING]; // RULE_09 RULE_10
                        end
                    end else begin
                        word_ff <= word_ff - step;
                    end
                end
            endcase
        end
    end
endmodule : dmc_channel
`default_nettype wire

/* core/dmc_top.sv */
// dma channel mode control: apb registers, six channels, arbitration, interrupt
//
// Behaviour
// (RULE_01) active_channel_code shows the moving channel 1..6, zero when idle
// (RULE_02) chan_irq_enable gates the channel interrupt to the expansion controller
// (RULE_03) word_width_select picks 16-bit or 32-bit moves on the data bus
// (RULE_04) all counts stay in 16-bit words whatever the move width
// (RULE_05) software must set steps and sizes to suit 32-bit moves
// (RULE_06) unused sync select and sync enable bits do nothing
// (RULE_07) continuous mode reloads at transfer end and waits for a trigger
// (RULE_08) without continuous mode the channel stops and clears run status
// (RULE_09) auto_burst_chaining runs all later bursts from one trigger
// (RULE_10) without chaining each accepted trigger runs exactly one burst
// (RULE_11) chan_irq_timing: zero fires at transfer start, one at transfer end
// (RULE_12) trigger_gate_enable clear ignores peripheral and forced triggers
// (RULE_13) overflow_irq_enable lets a detected overflow raise an interrupt
// (RULE_14) overflow is a new peripheral trigger while the pending flag is set
// (RULE_15) pending_trigger_flag holds from latch until the channel serves it
// (RULE_16) mode register resets to zero, reserved bits read zero
// (RULE_17) trigger_source_select picks which peripheral source starts a burst
// (RULE_18) mode writes need protected_write_permission, else silently dropped
// (RULE_19) reserved mode bits 6 and 5 read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module dmc_top
    import dmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic protected_write_permission,
    input wire logic [TRIG_SRC_N-1:0] periph_evt,
    output logic irq,
    output logic [CH_IDX_W-1:0] active_channel_code,
    output logic move_valid,
    output logic move_wide,
    output logic [CH_IDX_W-1:0] move_chan
);
    logic [15:0] mode_ff [NUM_CH];
    logic [15:0] size_ff [NUM_CH];
    logic [31:0] istat_ff;
    logic [31:0] imask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [CH_IDX_W-1:0] active_ff;
    logic move_valid_ff;
    logic move_wide_ff;
    logic [CH_IDX_W-1:0] move_chan_ff;

    logic [NUM_CH-1:0] want;
    logic [NUM_CH-1:0] busy;
    logic [NUM_CH-1:0] done;
    logic [NUM_CH-1:0] move;
    logic [NUM_CH-1:0] wide;
    logic [NUM_CH-1:0] pend_sts;
    logic [NUM_CH-1:0] run_sts;
    logic [NUM_CH-1:0] ovf_sts;
    logic [NUM_CH-1:0] chan_evt;
    logic [NUM_CH-1:0] ovf_evt;
    logic [NUM_CH-1:0] sel_evt;
    logic [NUM_CH-1:0] grant;
    logic [31:0] irq_set;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic wr_commit;
    logic [CH_IDX_W-1:0] nxt_active;

    // channel index of a per-channel word, or NUM_CH when out of range
    function automatic logic [CH_IDX_W-1:0] ch_of(input logic [7:0] addr);
        if (addr[1:0] != 2'h0 || addr[4:2] >= CH_IDX_W'(NUM_CH)) begin
            ch_of = CH_IDX_W'(NUM_CH);
        end else begin
            ch_of = addr[4:2];
        end
    endfunction : ch_of

    // source codes with no peripheral behind them never trigger
    function automatic logic trig_pick(input logic [TRIG_SRC_N-1:0] evt,
                                       input logic [4:0] src);
        if (src < 5'd3 || src >= 5'(TRIG_SRC_N)) begin
            trig_pick = 1'b0;
        end else begin
            trig_pick = evt[src];
        end
    endfunction : trig_pick

    // writes land only at the access edge the master samples pready on
    assign wr_commit = psel & penable & pready_ff & pwrite;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic hit_ctrl;
            assign hit_ctrl = wr_commit && paddr[7:5] == REGION_CTRL
                && ch_of(paddr) == CH_IDX_W'(gi);
            assign sel_evt[gi] = trig_pick(periph_evt,
                mode_ff[gi][MODE_SRC_MSB:MODE_SRC_LSB]); // RULE_17
            assign grant[gi] = (active_ff == CH_IDX_W'(gi + 1));

            dmc_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .mode(mode_ff[gi]),
                .size_cfg(size_ff[gi]),
                .periph_evt(sel_evt[gi]),
                .run_set(hit_ctrl & pwdata[CTRL_RUN]),
                .halt_set(hit_ctrl & pwdata[CTRL_HALT]),
                .force_set(hit_ctrl & pwdata[CTRL_FORCE]),
                .pend_clr(hit_ctrl & pwdata[CTRL_PEND_CLR]),
                .err_clr(hit_ctrl & pwdata[CTRL_ERR_CLR]),
                .grant(grant[gi]),
                .want(want[gi]),
                .busy(busy[gi]),
                .done(done[gi]),
                .move(move[gi]),
                .wide(wide[gi]),
                .pend_sts(pend_sts[gi]),
                .run_sts(run_sts[gi]),
                .ovf_sts(ovf_sts[gi]),
                .chan_evt(chan_evt[gi]),
                .ovf_evt(ovf_evt[gi])
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode_ff[gi] <= MODE_RESET; // RULE_16
                end else if (wr_commit && protected_write_permission // RULE_18
                             && paddr[7:5] == REGION_MODE
                             && ch_of(paddr) == CH_IDX_W'(gi)) begin
                    mode_ff[gi] <= pwdata[15:0] & MODE_WR_MASK; // RULE_19 RULE_06
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    size_ff[gi] <= SIZE_RESET;
                end else if (wr_commit && paddr[7:5] == REGION_SIZE
                             && ch_of(paddr) == CH_IDX_W'(gi)) begin
                    size_ff[gi] <= pwdata[15:0];
                end
            end

            assign irq_set[gi] = chan_evt[gi]
                & mode_ff[gi][MODE_CHAN_IRQ_ENABLE]; // RULE_02
            assign irq_set[ISTAT_OVF_LSB + gi] = ovf_evt[gi]
                & mode_ff[gi][MODE_OVERFLOW_IRQ_ENABLE]; // RULE_13
        end
    endgenerate

    assign irq_set[ISTAT_OVF_LSB-1:NUM_CH] = '0;
    assign irq_set[31:ISTAT_OVF_LSB+NUM_CH] = '0;

    // fixed priority: lowest channel wins, a burst runs to its end unbroken
    // a grant whose channel stopped wanting before its burst began is handed back
    always_comb begin
        nxt_active = active_ff;
        if (active_ff == NO_ACTIVE) begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
                if (want[i]) begin
                    nxt_active = CH_IDX_W'(i + 1);
                end
            end
        end else if (done[active_ff - CH_IDX_W'(1)]
                     || !(want[active_ff - CH_IDX_W'(1)]
                          || busy[active_ff - CH_IDX_W'(1)])) begin
            nxt_active = NO_ACTIVE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= NO_ACTIVE;
        end else begin
            active_ff <= nxt_active; // RULE_01
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            move_valid_ff <= 1'b0;
            move_wide_ff <= 1'b0;
            move_chan_ff <= NO_ACTIVE;
        end else begin
            move_valid_ff <= |move;
            move_wide_ff <= |(move & wide); // RULE_03
            move_chan_ff <= active_ff;
        end
    end

    // sticky events: a set in the same cycle as a one-write clear survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_ff <= IRQ_RESET;
        end else if (wr_commit && paddr == ISTAT_OFF) begin
            istat_ff <= (istat_ff & ~pwdata) | irq_set;
        end else begin
            istat_ff <= istat_ff | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_ff <= IRQ_RESET;
        end else if (wr_commit && paddr == IMASK_OFF) begin
            imask_ff <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(istat_ff & imask_ff); // RULE_02 RULE_13
        end
    end

    // read data is built in the setup cycle so the slave answers with no wait
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (paddr == ACTIVE_OFF) begin
            nxt_rdata = {29'h0, active_ff}; // RULE_01
        end else if (paddr == ISTAT_OFF) begin
            nxt_rdata = istat_ff;
        end else if (paddr == IMASK_OFF) begin
            nxt_rdata = imask_ff;
        end else if (ch_of(paddr) == CH_IDX_W'(NUM_CH)) begin
            nxt_err = 1'b1;
        end else begin
            unique case (paddr[7:5])
                REGION_MODE: nxt_rdata = {16'h0000, mode_ff[ch_of(paddr)]};
                REGION_SIZE: nxt_rdata = {16'h0000, size_ff[ch_of(paddr)]};
                REGION_CTRL: begin
                    nxt_rdata[CTRL_PEND_STS] = pend_sts[ch_of(paddr)];
                    nxt_rdata[CTRL_RUN_STS] = run_sts[ch_of(paddr)]; // RULE_08
                    nxt_rdata[CTRL_OVF_STS] = ovf_sts[ch_of(paddr)];
                end
                default: nxt_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            pready_ff <= 1'b1;
            pslverr_ff <= nxt_err;
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign active_channel_code = active_ff;
    assign move_valid = move_valid_ff;
    assign move_wide = move_wide_ff;
    assign move_chan = move_chan_ff;
endmodule : dmc_top
`default_nettype wire

/* tb/dmc_monitor.sv */
// port-level assertion checker for the dma channel mode control block
`timescale 1ns/1ps
`default_nettype none
module dmc_monitor
    import dmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [CH_IDX_W-1:0] active_channel_code,
    input wire logic move_valid,
    input wire logic [CH_IDX_W-1:0] move_chan
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && pready && !pwrite;
    wire wr_acc = psel && penable && pready && pwrite;

    a_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without a setup cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access cycle");
    a_unmapped_rd: assert property (rd_acc && paddr >= 8'h6C |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_mode_resv: assert property (rd_acc && paddr < CTRL_BASE |-> prdata[31:16] == 16'h0 && prdata[6:5] == 2'h0)
        else $error("reserved mode bits not zero");
    a_active_code: assert property (active_channel_code <= 3'h6)
        else $error("active code out of range");
    a_active_rd: assert property (rd_acc && paddr == ACTIVE_OFF |-> prdata[31:3] == 29'h0)
        else $error("active word has stray bits");
    a_move_chan: assert property (move_valid |-> move_chan inside {[3'h1:3'h6]})
        else $error("move without a channel");
    a_mask_quiet: assert property (wr_acc && paddr == IMASK_OFF && pwdata[13:0] == 14'h0 |=> ##1 !irq)
        else $error("irq high with all masked");
endmodule : dmc_monitor

bind dmc_top dmc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .active_channel_code, .move_valid, .move_chan);
`default_nettype wire

/* tb/dmc_evt_src.sv */
// peripheral event source model: single-cycle trigger pulses
`timescale 1ns/1ps
`default_nettype none
module dmc_evt_src
    import dmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [4:0] src,
    output logic [TRIG_SRC_N-1:0] periph_evt
);
    logic [TRIG_SRC_N-1:0] pulse_ff;
    assign periph_evt = pulse_ff;
    // a real source pulses once per event and never holds its line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_ff <= '0;
        end else begin
            pulse_ff <= '0;
            if (fire) begin
                pulse_ff[src] <= 1'b1;
            end
        end
    end
endmodule : dmc_evt_src
`default_nettype wire

/* tb/dmc_top_tb.sv */
// self-checking bench for the dma channel mode control block
`timescale 1ns/1ps
`default_nettype none
module dmc_top_tb
    import dmc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic perm = 1'b0, fire = 1'b0, pready, pslverr, irq, mv, mw, err, wseen;
    logic [4:0] src = 5'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] act, mc, cseen, aseen;
    logic [TRIG_SRC_N-1:0] evt;
    int errors = 0, n_compared = 0, nmv;
    always #25 pclk = ~pclk;
    dmc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .protected_write_permission(perm), .periph_evt(evt), .irq,
        .active_channel_code(act), .move_valid(mv), .move_wide(mw), .move_chan(mc));
    dmc_evt_src u_src (.pclk, .presetn, .fire, .src, .periph_evt(evt));

    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // the master never assumes a latency: it waits for pready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rdchk

    task automatic pulse(input logic [4:0] s);
        @(posedge pclk);
        fire <= 1'b1;
        src <= s;
        @(posedge pclk);
        fire <= 1'b0;
    endtask : pulse

    // counts data moves over a window; width and channel of the last one kept
    task automatic moves(input logic [31:0] exp, input logic [31:0] ew);
        nmv = 0;
        wseen = 1'b0;
        cseen = 3'h0;
        aseen = 3'h0;
        repeat (24) begin
            @(posedge pclk);
            if (act !== 3'h0) begin
                aseen = act;
            end
            if (mv === 1'b1) begin
                nmv++;
                wseen = mw;
                cseen = mc;
            end
        end
        check("move count", 32'(nmv), exp);
        check("move kind", 32'({wseen, cseen}), ew);
        check("active code", 32'(aseen), 32'(ew[2:0]));
        check("active end", 32'(act), 32'h0);
    endtask : moves

    task automatic t_reset;
        for (int n = 0; n < NUM_CH; n++) begin
            rdchk("mode reset", MODE_BASE + 8'(4 * n), 32'h0);
        end
        rdchk("active idle", ACTIVE_OFF, 32'h0);
        apb(1'b0, 8'h70, 32'h0);
        check("unmapped", 32'(err), 32'h1);
    endtask : t_reset

    task automatic t_protect;
        apb(1'b1, 8'h04, 32'hFFFF);
        rdchk("mode locked", 8'h04, 32'h0);
        perm <= 1'b1;
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        rdchk("mode bits", 8'h04, 32'hFF9F);
        apb(1'b1, 8'h04, 32'h0);
    endtask : t_protect

    task automatic t_gate;
        apb(1'b1, 8'h00, 32'h0003);
        apb(1'b1, 8'h40, 32'h0003);
        apb(1'b1, 8'h20, 32'h1);
        pulse(5'd3);
        apb(1'b1, 8'h20, 32'h8);
        moves(32'h0, 32'h0);
        rdchk("gated pend", 8'h20, 32'h2000);
    endtask : t_gate

    task automatic t_single;
        apb(1'b1, IMASK_OFF, 32'h3F3F);
        apb(1'b1, 8'h00, 32'h8103);
        pulse(5'd3);
        moves(32'h4, 32'h1);
        rdchk("stopped", 8'h20, 32'h0);
        rdchk("start irq", ISTAT_OFF, 32'h1);
        check("irq on", 32'(irq), 32'h1);
        apb(1'b1, ISTAT_OFF, 32'h1);
        rdchk("irq cleared", ISTAT_OFF, 32'h0);
    endtask : t_single

    task automatic t_wide;
        apb(1'b1, 8'h00, 32'h4103);
        apb(1'b1, 8'h20, 32'h1);
        pulse(5'd3);
        moves(32'h2, 32'h9);
        rdchk("irq off", ISTAT_OFF, 32'h0);
    endtask : t_wide

    task automatic t_nochain;
        apb(1'b1, 8'h00, 32'h8303);
        apb(1'b1, 8'h40, 32'h0101);
        apb(1'b1, 8'h20, 32'h1);
        pulse(5'd3);
        moves(32'h2, 32'h1);
        rdchk("not at end", ISTAT_OFF, 32'h0);
        pulse(5'd3);
        moves(32'h2, 32'h1);
        rdchk("at end", ISTAT_OFF, 32'h1);
        apb(1'b1, ISTAT_OFF, 32'h1);
    endtask : t_nochain

    task automatic t_chain;
        apb(1'b1, 8'h00, 32'h3503);
        apb(1'b1, 8'h20, 32'h1);
        pulse(5'd3);
        moves(32'h4, 32'h1);
    endtask : t_chain

    task automatic t_cont;
        apb(1'b1, 8'h00, 32'h0903);
        apb(1'b1, 8'h40, 32'h0000);
        apb(1'b1, 8'h20, 32'h1);
        pulse(5'd3);
        moves(32'h1, 32'h1);
        rdchk("still run", 8'h20, 32'h2000);
        pulse(5'd3);
        moves(32'h1, 32'h1);
        apb(1'b1, 8'h20, 32'h2);
    endtask : t_cont

    task automatic t_ovf;
        apb(1'b1, 8'h00, 32'h0183);
        pulse(5'd4);
        rdchk("other source", 8'h20, 32'h0);
        pulse(5'd3);
        rdchk("pending", 8'h20, 32'h100);
        pulse(5'd3);
        rdchk("overflow", 8'h20, 32'h4100);
        rdchk("ovf status", ISTAT_OFF, 32'h100);
        check("ovf irq", 32'(irq), 32'h1);
        apb(1'b1, 8'h20, 32'h90);
        apb(1'b1, ISTAT_OFF, 32'h100);
        apb(1'b1, IMASK_OFF, 32'h0);
        rdchk("flags clear", 8'h20, 32'h0);
        check("irq quiet", 32'(irq), 32'h0);
    endtask : t_ovf

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_protect();
        t_gate();
        t_single();
        // even word count keeps 32-bit moves whole
        apb(1'b1, 8'h40, 32'h0003);
        t_wide();
        t_nochain();
        t_chain();
        t_cont();
        t_ovf();
        finish_test();
    end
endmodule : dmc_top_tb
`default_nettype wire
